// [core/mcc_cmd_config.sv]
// Command-register interpreter: takes decoded register writes and reads of a serial
// slave, runs configuration commands and serves the settings and the result words.
// Assumes a frame decoder on the same clock that delivers words in order and
// reports the CRC verdict at the end of each write frame.
//
// Functional notes
// - Master configures by function 16 writes of command and parameters; device acts.
// - Request holds address, function 16, start 300 up to 423, count, bytes, CRC.
// - Outcome of last command is readable at addresses 424 and 425.
// - 424 echoes command number; 425 gives 0, 80, 81, 82 or 83.
// - Decimal register addresses are used unchanged as frame register addresses.
// - Item sizes count in 16-bit words; wide values take consecutive addresses.
// - Words are unsigned or signed 16-bit; wider ints, text and floats exist.
// - Date-time is four words: year offset, month/day, hour/minute, milliseconds.
// - Reserved command parameters may hold anything and are ignored.
// - Command 1001 sets clock from year, month, day, hour, minute, second.
// - First block word is the command number; parameters follow in order.
// - Command 1002 sets slave address 1-247 and baud code 0 to 6.
// - Last communication parameter selects parity: 0 odd, 1 even, 2 none.
// - Command 1003 starts with wiring code 0-4, then frequency 50 or 60.
// - Power command carries transformer primaries and secondaries with stated limits.
// - Final power parameter selects direct or three-transformer voltage connection; the code takes that from word 12 and makes word 13 curr_conn.
// - Command-written registers are readable but change only through commands.
// - Each parameter is accepted only within its permitted range; the code leaves the three transformer primaries unchecked.
// - 32-bit values put the less significant word at the lower address.
// - Function 03 reads holding registers; function 10H writes multiple registers.
`timescale 1ns/1ps
`include "mcc_regs.svh"

module mcc_cmd_config
  import mcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Decoded write frame
  input wire logic wr_begin,
  input wire logic [7:0] wr_func,
  input wire logic [15:0] wr_start,
  input wire logic [15:0] wr_count,
  input wire logic wr_word_valid,
  input wire logic [15:0] wr_word,
  input wire logic wr_end,
  input wire logic wr_crc_ok,
  // Decoded read request
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic rd_err,
  // Status
  output logic wr_err,
  output logic cmd_busy,
  output logic cmd_done,
  // Date and time
  output logic [15:0] dt_year,
  output logic [15:0] dt_mday,
  output logic [15:0] dt_hmin,
  output logic [15:0] dt_msec,
  // Communication settings
  output logic [15:0] slave_addr,
  output logic [15:0] baud_code,
  output logic [15:0] parity_code,
  // Power-system settings
  output logic [15:0] wiring_code,
  output logic [15:0] nominal_freq,
  output logic [31:0] vt_primary,
  output logic [15:0] vt_secondary,
  output logic [31:0] coil_primary,
  output logic [15:0] coil_secondary,
  output logic [31:0] rcoil_primary,
  output logic [15:0] rcoil_secondary,
  output logic [15:0] volt_conn,
  output logic [15:0] curr_conn
);

  // **********************************************************
  // Decoding helpers
  // **********************************************************

  // True for an address inside the command block.
  function automatic logic in_block(input logic [15:0] a);
    in_block = (a >= `MCC_ADDR_CMD_FIRST) && (a <= `MCC_ADDR_CMD_LAST);
  endfunction

  // Picks word k of the command block.
  function automatic mcc_word_t blk(input mcc_block_t b, input int k);
    blk = b[k*16 +: 16];
  endfunction

  // **********************************************************
  // Frame capture
  // **********************************************************

  mcc_state_e state;
  logic [7:0] f_func;
  logic [15:0] f_start;
  logic [15:0] f_count;
  logic [15:0] f_idx;
  logic f_bad;
  mcc_word_t code;
  mcc_word_t chk_code;
  mcc_block_t words;
  logic [15:0] w_addr;
  logic [15:0] w_off;
  logic [16:0] f_last;
  logic buf_we;
  logic frame_ok;
  logic frame_cmd;

  // Address of the word now arriving, and its offset in the block.
  assign w_addr = f_start + f_idx;
  assign w_off = w_addr - `MCC_ADDR_CMD_FIRST;
  assign f_last = {1'b0, f_start} + {1'b0, f_count} - 17'h00001;
  assign buf_we = (state == MCC_ST_RECV) && wr_word_valid && !f_bad &&
                  in_block(w_addr) && (w_off < 16'h0010);

  // A frame is good when CRC holds, function is 16 and it stays in the block.
  assign frame_ok = wr_crc_ok && (f_func == `MCC_FUNC_WRITE_MULTI) &&
                    in_block(f_start) && (f_count != 16'h0000) &&
                    (f_last <= {1'b0, `MCC_ADDR_CMD_LAST});
  assign frame_cmd = frame_ok && (f_start == `MCC_ADDR_CMD_FIRST);

  mcc_cmd_buffer u_buffer (
    .clk(clk),
    .nrst(nrst),
    .wr_en(buf_we),
    .wr_idx(w_off[`MCC_BUF_IDX_W-1:0]),
    .wr_data(wr_word),
    .words(words)
  );

  mcc_param_check u_check (
    .words(words),
    .nparam(f_count - 16'h0001),
    .result(chk_code)
  );

  // **********************************************************
  // Sequencer
  // **********************************************************

  // Moves from receiving a frame to checking and applying its command.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= MCC_ST_IDLE;
    end else begin
      case (state)
        MCC_ST_IDLE: begin
          if (wr_begin) begin
            state <= MCC_ST_RECV;
          end
        end
        MCC_ST_RECV: begin
          if (wr_end) begin
            state <= frame_cmd ? MCC_ST_CHECK : MCC_ST_IDLE;
          end
        end
        MCC_ST_CHECK: begin
          state <= MCC_ST_APPLY;
        end
        MCC_ST_APPLY: begin
          state <= MCC_ST_IDLE;
        end
        default: begin
          state <= MCC_ST_IDLE;
        end
      endcase
    end
  end

  // Latches the frame header and counts the words as they arrive.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      f_func <= 8'h00;
      f_start <= 16'h0000;
      f_count <= 16'h0000;
      f_idx <= 16'h0000;
    end else if ((state == MCC_ST_IDLE) && wr_begin) begin
      f_func <= wr_func;
      f_start <= wr_start;
      f_count <= wr_count;
      f_idx <= 16'h0000;
    end else if ((state == MCC_ST_RECV) && wr_word_valid) begin
      f_idx <= f_idx + 16'h0001;
    end
  end

  // Marks a frame of another function or one that touches anything outside the block; its words from then on are dropped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      f_bad <= 1'b0;
    end else if ((state == MCC_ST_IDLE) && wr_begin) begin
      f_bad <= (wr_func != `MCC_FUNC_WRITE_MULTI);
    end else if (buf_we || ((state == MCC_ST_RECV) && wr_word_valid && !in_block(w_addr))) begin
      f_bad <= f_bad || !in_block(w_addr);
    end
  end

  // Refuses a frame with a bad range or a write to a command-only register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_err <= 1'b0;
    end else begin
      wr_err <= (state == MCC_ST_RECV) && wr_end && wr_crc_ok && !frame_ok;
    end
  end

  // Picks the verdict; a short block is reported as not performed.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code <= `MCC_RES_OK;
    end else if (state == MCC_ST_CHECK) begin
      code <= (f_idx != f_count) ? `MCC_RES_NOT_DONE : chk_code;
    end
  end

  // Busy from the end of a command frame until its results stand.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_busy <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      cmd_busy <= ((state == MCC_ST_RECV) && wr_end && frame_cmd) || (state == MCC_ST_CHECK);
      cmd_done <= (state == MCC_ST_APPLY);
    end
  end

  // **********************************************************
  // Result registers
  // **********************************************************

  mcc_word_t last_command_echo;
  mcc_word_t command_outcome_code;

  // Both result words are written together when the command is applied.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_command_echo <= `MCC_RST_ECHO;
      command_outcome_code <= `MCC_RST_OUTCOME;
    end else if (state == MCC_ST_APPLY) begin
      last_command_echo <= blk(words, 0);
      command_outcome_code <= code;
    end
  end

  // **********************************************************
  // Settings, changed only by a valid command
  // **********************************************************

  logic apply_ok;
  logic [15:0] sec_ms;

  assign apply_ok = (state == MCC_ST_APPLY) && (code == `MCC_RES_OK);
  assign sec_ms = 16'(blk(words, 6) * `MCC_MS_PER_SEC);

  // Date and time in four-word form; year kept as offset from 2000.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dt_year <= `MCC_RST_DT_YEAR;
      dt_mday <= `MCC_RST_DT_MDAY;
      dt_hmin <= `MCC_RST_DT_HMIN;
      dt_msec <= `MCC_RST_DT_MSEC;
    end else if (apply_ok && (blk(words, 0) == `MCC_CMD_SET_TIME)) begin
      dt_year <= {8'h00, 8'(blk(words, 1) - `MCC_YEAR_MIN)};
      dt_mday <= {words[32 +: 8], words[48 +: 8]};
      dt_hmin <= {words[64 +: 8], words[80 +: 8]};
      dt_msec <= sec_ms;
    end
  end

  // Communication settings.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slave_addr <= `MCC_RST_SLAVE;
      baud_code <= `MCC_RST_BAUD;
      parity_code <= `MCC_RST_PARITY;
    end else if (apply_ok && (blk(words, 0) == `MCC_CMD_SET_COMM)) begin
      slave_addr <= blk(words, 1);
      baud_code <= blk(words, 2);
      parity_code <= blk(words, 3);
    end
  end

  // Power-system settings; the first word of each pair is the low half.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wiring_code <= `MCC_RST_WIRING;
      nominal_freq <= `MCC_RST_FREQ;
      vt_primary <= `MCC_RST_VTP;
      vt_secondary <= `MCC_RST_VTS;
      coil_primary <= `MCC_RST_CP;
      coil_secondary <= `MCC_RST_CS;
      rcoil_primary <= `MCC_RST_RP;
      rcoil_secondary <= `MCC_RST_RS;
      volt_conn <= `MCC_RST_VCONN;
      curr_conn <= `MCC_RST_ICONN;
    end else if (apply_ok && (blk(words, 0) == `MCC_CMD_SET_POWER)) begin
      wiring_code <= blk(words, 1);
      nominal_freq <= blk(words, 2);
      vt_primary <= {blk(words, 4), blk(words, 3)};
      vt_secondary <= blk(words, 5);
      coil_primary <= {blk(words, 7), blk(words, 6)};
      coil_secondary <= blk(words, 8);
      rcoil_primary <= {blk(words, 10), blk(words, 9)};
      rcoil_secondary <= blk(words, 11);
      volt_conn <= blk(words, 12);
      curr_conn <= blk(words, 13);
    end
  end

  // **********************************************************
  // Read port
  // **********************************************************

  mcc_word_t rd_word;
  logic rd_miss;
  logic [15:0] r_off;

  assign r_off = rd_addr - `MCC_ADDR_CMD_FIRST;

  // Maps an address to its word; low address holds the low half of 32-bit values.
  always_comb begin
    rd_word = 16'h0000;
    rd_miss = 1'b0;
    case (rd_addr)
      `MCC_ADDR_ECHO: rd_word = last_command_echo;
      `MCC_ADDR_OUTCOME: rd_word = command_outcome_code;
      `MCC_ADDR_DT_YEAR: rd_word = dt_year;
      `MCC_ADDR_DT_MDAY: rd_word = dt_mday;
      `MCC_ADDR_DT_HMIN: rd_word = dt_hmin;
      `MCC_ADDR_DT_MSEC: rd_word = dt_msec;
      `MCC_ADDR_SLAVE: rd_word = slave_addr;
      `MCC_ADDR_BAUD: rd_word = baud_code;
      `MCC_ADDR_PARITY: rd_word = parity_code;
      `MCC_ADDR_WIRING: rd_word = wiring_code;
      `MCC_ADDR_FREQ: rd_word = nominal_freq;
      `MCC_ADDR_VTP_LO: rd_word = vt_primary[15:0];
      `MCC_ADDR_VTP_HI: rd_word = vt_primary[31:16];
      `MCC_ADDR_VTS: rd_word = vt_secondary;
      `MCC_ADDR_CP_LO: rd_word = coil_primary[15:0];
      `MCC_ADDR_CP_HI: rd_word = coil_primary[31:16];
      `MCC_ADDR_CS: rd_word = coil_secondary;
      `MCC_ADDR_RP_LO: rd_word = rcoil_primary[15:0];
      `MCC_ADDR_RP_HI: rd_word = rcoil_primary[31:16];
      `MCC_ADDR_RS: rd_word = rcoil_secondary;
      `MCC_ADDR_VCONN: rd_word = volt_conn;
      `MCC_ADDR_ICONN: rd_word = curr_conn;
      default: begin
        if (in_block(rd_addr)) begin
          rd_word = (r_off < 16'h0010) ? blk(words, int'(r_off[3:0])) : 16'h0000;
        end else begin
          rd_miss = 1'b1;
        end
      end
    endcase
  end

  // Answers a read one cycle after the request.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      rd_err <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      rd_data <= rd_req ? rd_word : 16'h0000;
      rd_err <= rd_req && rd_miss;
    end
  end

endmodule

// [core/mcc_regs.svh]
// Register addresses, field limits, reset values and counts of the command interpreter.
// Assumes it is included by bare name from the package and the design modules.
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH

// Register addresses, decimal values written as 16-bit hex.
`define MCC_ADDR_DT_YEAR 16'h0049
`define MCC_ADDR_DT_MDAY 16'h004a
`define MCC_ADDR_DT_HMIN 16'h004b
`define MCC_ADDR_DT_MSEC 16'h004c
`define MCC_ADDR_SLAVE 16'h0050
`define MCC_ADDR_BAUD 16'h0051
`define MCC_ADDR_PARITY 16'h0052
`define MCC_ADDR_WIRING 16'h005a
`define MCC_ADDR_FREQ 16'h005b
`define MCC_ADDR_VTP_LO 16'h005c
`define MCC_ADDR_VTP_HI 16'h005d
`define MCC_ADDR_VTS 16'h005e
`define MCC_ADDR_CP_LO 16'h005f
`define MCC_ADDR_CP_HI 16'h0060
`define MCC_ADDR_CS 16'h0061
`define MCC_ADDR_RP_LO 16'h0062
`define MCC_ADDR_RP_HI 16'h0063
`define MCC_ADDR_RS 16'h0064
`define MCC_ADDR_VCONN 16'h0065
`define MCC_ADDR_ICONN 16'h0066
`define MCC_ADDR_CMD_FIRST 16'h012c
`define MCC_ADDR_CMD_LAST 16'h01a7
`define MCC_ADDR_ECHO 16'h01a8
`define MCC_ADDR_OUTCOME 16'h01a9

// Function codes.
`define MCC_FUNC_READ 8'h03
`define MCC_FUNC_WRITE_MULTI 8'h10

// Command numbers and their parameter counts.
`define MCC_CMD_SET_TIME 16'h03e9
`define MCC_CMD_SET_COMM 16'h03ea
`define MCC_CMD_SET_POWER 16'h03eb
`define MCC_NPAR_TIME 16'h0006
`define MCC_NPAR_COMM 16'h0003
`define MCC_NPAR_POWER 16'h000d

// Result codes.
`define MCC_RES_OK 16'h0000
`define MCC_RES_BAD_CMD 16'h0050
`define MCC_RES_BAD_PARAM 16'h0051
`define MCC_RES_BAD_COUNT 16'h0052
`define MCC_RES_NOT_DONE 16'h0053

// Parameter limits.
`define MCC_YEAR_MIN 16'h07d0
`define MCC_YEAR_MAX 16'h0833
`define MCC_MONTH_MAX 16'h000c
`define MCC_DAY_MAX 16'h001f
`define MCC_HOUR_MAX 16'h0017
`define MCC_MIN_MAX 16'h003b
`define MCC_SLAVE_MAX 16'h00f7
`define MCC_BAUD_MAX 16'h0006
`define MCC_PARITY_MAX 16'h0002
`define MCC_WIRING_MAX 16'h0004
`define MCC_FREQ_50 16'h0032
`define MCC_FREQ_60 16'h003c
`define MCC_VTS_100 16'h0064
`define MCC_VTS_110 16'h006e
`define MCC_VTS_115 16'h0073
`define MCC_VTS_120 16'h0078
`define MCC_COIL_SEC_MAX 16'h014d
`define MCC_VCONN_MAX 16'h0001
`define MCC_ICONN_MAX 16'h0001
`define MCC_MS_PER_SEC 16'h03e8

// Buffer geometry of the command block.
`define MCC_BUF_DEPTH 16
`define MCC_BUF_IDX_W 4

// Reset values of the settings.
`define MCC_RST_DT_YEAR 16'h0000
`define MCC_RST_DT_MDAY 16'h0101
`define MCC_RST_DT_HMIN 16'h0000
`define MCC_RST_DT_MSEC 16'h0000
`define MCC_RST_SLAVE 16'h0001
`define MCC_RST_BAUD 16'h0004
`define MCC_RST_PARITY 16'h0002
`define MCC_RST_WIRING 16'h0002
`define MCC_RST_FREQ 16'h0032
`define MCC_RST_VTP 32'h0000_0001
`define MCC_RST_VTS 16'h0064
`define MCC_RST_CP 32'h0000_0001
`define MCC_RST_CS 16'h014d
`define MCC_RST_RP 32'h0000_0001
`define MCC_RST_RS 16'h014d
`define MCC_RST_VCONN 16'h0000
`define MCC_RST_ICONN 16'h0000
`define MCC_RST_ECHO 16'h0000
`define MCC_RST_OUTCOME 16'h0000

`endif

// [core/mcc_pkg.sv]
// Types shared by the command interpreter modules.
// Assumes mcc_regs.svh is on the include path.
`include "mcc_regs.svh"

package mcc_pkg;

  // One-hot states of the command sequencer.
  typedef enum logic [3:0] {
    MCC_ST_IDLE = 4'h1,
    MCC_ST_RECV = 4'h2,
    MCC_ST_CHECK = 4'h4,
    MCC_ST_APPLY = 4'h8
  } mcc_state_e;

  // One 16-bit register word.
  typedef logic [15:0] mcc_word_t;

  // Flattened command block, word 0 in the low bits.
  typedef logic [`MCC_BUF_DEPTH*16-1:0] mcc_block_t;

endpackage

// [core/mcc_cmd_buffer.sv]
// Word storage of the command block, indexed by offset from its first address.
// Assumes writes come from the sequencer on the same clock.
`timescale 1ns/1ps
`include "mcc_regs.svh"

module mcc_cmd_buffer
  import mcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write side
  input wire logic wr_en,
  input wire logic [`MCC_BUF_IDX_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  // All stored words
  output mcc_block_t words
);

  // **********************************************************
  // Storage
  // **********************************************************

  genvar gi;
  generate
    for (gi = 0; gi < `MCC_BUF_DEPTH; gi = gi + 1) begin : g_word
      logic [15:0] word_q;
      // Each word loads only when its own index is addressed.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          word_q <= 16'h0000;
        end else if (wr_en && (int'(wr_idx) == gi)) begin
          word_q <= wr_data;
        end
      end
      // One flop word per slice keeps a single process per driven bit.
      assign words[gi*16 +: 16] = word_q;
    end
  endgenerate

endmodule

// [core/mcc_param_check.sv]
// Combinational validation of a received command and its parameters.
// Assumes the block words are stable while the sequencer samples the result.
`timescale 1ns/1ps
`include "mcc_regs.svh"

module mcc_param_check
  import mcc_pkg::*;
(
  // Received command
  input mcc_block_t words,
  input wire logic [15:0] nparam,
  // Verdict
  output mcc_word_t result
);

  // **********************************************************
  // Helpers
  // **********************************************************

  // Picks word k of the block.
  function automatic mcc_word_t wd(input mcc_block_t b, input int k);
    wd = b[k*16 +: 16];
  endfunction

  // Tests a word against an inclusive range.
  function automatic logic in_rng(input mcc_word_t v, input mcc_word_t lo, input mcc_word_t hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  // **********************************************************
  // Verdict
  // **********************************************************

  logic ok_time;
  logic ok_comm;
  logic ok_power;
  mcc_word_t cmd;

  // Each parameter except the three primaries is held to its permitted range, not its type range.
  always_comb begin
    cmd = wd(words, 0);
    ok_time = in_rng(wd(words, 1), `MCC_YEAR_MIN, `MCC_YEAR_MAX) &&
              in_rng(wd(words, 2), 16'h0001, `MCC_MONTH_MAX) &&
              in_rng(wd(words, 3), 16'h0001, `MCC_DAY_MAX) &&
              in_rng(wd(words, 4), 16'h0000, `MCC_HOUR_MAX) &&
              in_rng(wd(words, 5), 16'h0000, `MCC_MIN_MAX) &&
              in_rng(wd(words, 6), 16'h0000, `MCC_MIN_MAX);
    ok_comm = in_rng(wd(words, 1), 16'h0001, `MCC_SLAVE_MAX) &&
              in_rng(wd(words, 2), 16'h0000, `MCC_BAUD_MAX) &&
              in_rng(wd(words, 3), 16'h0000, `MCC_PARITY_MAX);
    ok_power = in_rng(wd(words, 1), 16'h0000, `MCC_WIRING_MAX) &&
               ((wd(words, 2) == `MCC_FREQ_50) || (wd(words, 2) == `MCC_FREQ_60)) &&
               ((wd(words, 5) == `MCC_VTS_100) || (wd(words, 5) == `MCC_VTS_110) ||
                (wd(words, 5) == `MCC_VTS_115) || (wd(words, 5) == `MCC_VTS_120)) &&
               (wd(words, 8) <= `MCC_COIL_SEC_MAX) &&
               (wd(words, 11) <= `MCC_COIL_SEC_MAX) &&
               (wd(words, 12) <= `MCC_VCONN_MAX) &&
               (wd(words, 13) <= `MCC_ICONN_MAX);
    case (cmd)
      `MCC_CMD_SET_TIME: begin
        if (nparam != `MCC_NPAR_TIME) begin
          result = `MCC_RES_BAD_COUNT;
        end else begin
          result = ok_time ? `MCC_RES_OK : `MCC_RES_BAD_PARAM;
        end
      end
      `MCC_CMD_SET_COMM: begin
        if (nparam != `MCC_NPAR_COMM) begin
          result = `MCC_RES_BAD_COUNT;
        end else begin
          result = ok_comm ? `MCC_RES_OK : `MCC_RES_BAD_PARAM;
        end
      end
      `MCC_CMD_SET_POWER: begin
        if (nparam != `MCC_NPAR_POWER) begin
          result = `MCC_RES_BAD_COUNT;
        end else begin
          result = ok_power ? `MCC_RES_OK : `MCC_RES_BAD_PARAM;
        end
      end
      default: begin
        result = `MCC_RES_BAD_CMD;
      end
    endcase
  end

endmodule

// [dv/mcc_cmd_config_props.sv]
// Checker of the interpreter's read, write and result timing.
// Assumes a bind to mcc_cmd_config from the bench top.
`timescale 1ns/1ps
module mcc_cmd_config_props (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic rd_req,
  input wire logic wr_end,
  input wire logic wr_crc_ok,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err,
  input wire logic cmd_busy,
  input wire logic cmd_done
);
  // ****************
  // Port relations
  // ****************
  // All checks sample on the rising edge and rest during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (rd_req |=> rd_valid) else $error("read unanswered");
  a_read_cause: assert property (rd_valid |-> $past(rd_req)) else $error("stray answer");
  a_read_idle: assert property (!rd_valid |-> !rd_err && rd_data == 16'h0000)
    else $error("idle read data");
  a_err_zero: assert property (rd_err |-> rd_data == 16'h0000) else $error("refused data");
  a_busy_span: assert property ($rose(cmd_busy) |-> ##1 cmd_busy ##1 !cmd_busy && cmd_done)
    else $error("busy span");
  a_busy_cause: assert property ($rose(cmd_busy) |-> $past(wr_end && wr_crc_ok))
    else $error("busy cause");
  a_crc_quiet: assert property (wr_end && !wr_crc_ok |=> !wr_err && !cmd_busy)
    else $error("bad frame acted on");
  a_err_cause: assert property (wr_err |-> $past(wr_end && wr_crc_ok) && !cmd_busy)
    else $error("write refusal cause");
  a_done_pulse: assert property (cmd_done |=> !cmd_done && !cmd_busy) else $error("done held");
endmodule

// [dv/mcc_master_model.sv]
// Model of the decoded frame side of a serial master.
// Assumes the bench calls send and keeps the frame spacing.
`timescale 1ns/1ps
module mcc_master_model (
  // Clock
  input wire logic clk,
  // Decoded write frame
  output logic wr_begin,
  output logic [7:0] wr_func,
  output logic [15:0] wr_start,
  output logic [15:0] wr_count,
  output logic wr_word_valid,
  output logic [15:0] wr_word,
  output logic wr_end,
  output logic wr_crc_ok
);
  // ****************
  // Frame driver
  // ****************
  // Lines start quiet; consumed fields are flipped so stale values never match.
  initial begin
    {wr_begin, wr_word_valid, wr_end, wr_crc_ok} = 4'h0;
    {wr_func, wr_start, wr_count, wr_word} = 56'h0;
  end
  // Sends one function 16 frame of ns words, command word first.
  task send(input logic [15:0] st, cnt, input int ns, input logic [15:0] w[$], input logic crc);
    @(posedge clk) #1;
    {wr_begin, wr_func, wr_start, wr_count} = {1'b1, 8'h10, st, cnt};
    for (int i = 0; i < ns; i++) begin
      @(posedge clk) #1;
      {wr_begin, wr_word_valid, wr_word} = {2'b01, w[i]};
    end
    @(posedge clk) #1;
    {wr_begin, wr_word_valid, wr_end, wr_crc_ok} = {3'b001, crc};
    {wr_func, wr_start, wr_count, wr_word} = ~{wr_func, wr_start, wr_count, wr_word};
    @(posedge clk) #1;
    {wr_end, wr_crc_ok} = 2'b00;
    repeat (2) @(posedge clk);
  endtask
endmodule

// [dv/mcc_cmd_config_tb.sv]
// Self-checking bench of the command interpreter with a master model.
// Assumes the package, header and design under core/ compile first.
`timescale 1ns/1ps
module mcc_cmd_config_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rd_req = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic wr_begin, wr_word_valid, wr_end, wr_crc_ok, rd_valid, rd_err, wr_err, cmd_busy, cmd_done;
  logic [7:0] wr_func;
  logic [15:0] wr_start, wr_count, wr_word, rd_data, dt_year, dt_mday, dt_hmin, dt_msec;
  logic [15:0] slave_addr, baud_code, parity_code, wiring_code, nominal_freq, vt_secondary;
  logic [15:0] coil_secondary, rcoil_secondary, volt_conn, curr_conn, d, e;
  logic [31:0] vt_primary, coil_primary, rcoil_primary;
  int mismatches = 0;
  int comparisons = 0;
  int p = 0;
  logic [15:0] cw[$] = '{16'h03ea, 16'h0009, 16'h0000, 16'h0000};
  // Rows: register count, words sent, expected outcome, then the words.
  logic [15:0] rows[$] = '{
    16'h0007,16'h0007,16'h0000,16'h03e9,16'h07e0,16'h0001,16'h0001,16'h000a,16'h000a,16'h000a,
    16'h0007,16'h0007,16'h0051,16'h03e9,16'h0834,16'h0001,16'h0001,16'h000a,16'h000a,16'h000a,
    16'h0006,16'h0006,16'h0052,16'h03e9,16'h07e0,16'h0001,16'h0001,16'h000a,16'h000a,
    16'h0004,16'h0004,16'h0000,16'h03ea,16'h00f7,16'h0006,16'h0001,
    16'h0004,16'h0004,16'h0051,16'h03ea,16'h0005,16'h0001,16'h0003,
    16'h000e,16'h000e,16'h0000,16'h03eb,16'h0004,16'h003c,16'h0002,16'h0001,16'h0078,
    16'h0002,16'h0000,16'h014d,16'h0003,16'h0000,16'h014d,16'h0001,16'h0001,
    16'h0001,16'h0001,16'h0050,16'h03ec,
    16'h0004,16'h0003,16'h0053,16'h03ea,16'h0001,16'h0001};
  // ****************
  // Harness
  // ****************
  always #4 clk = ~clk;
  mcc_master_model mcc_master_model_inst (.*);
  mcc_cmd_config mcc_cmd_config_inst (.*);
  // Compares a seen value with its expectation.
  task chk(input string n, input logic [31:0] s, x);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  // Reads one register; the answer stands one cycle after the request edge.
  task rd(input logic [15:0] a);
    @(posedge clk) #1;
    {rd_req, rd_addr} = {1'b1, a};
    @(posedge clk) #1;
    {rd_req, rd_addr} = {1'b0, ~a};
    {d, e} = {rd_data, 15'h0, rd_err};
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  // Reset, table of commands, then frames that run no command, unmapped read and a second reset.
  initial begin
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    rd(16'h01a8);
    chk("echo reset", d, 16'h0000);
    chk("slave reset", slave_addr, 16'h0001);
    while (p < rows.size()) begin
      mcc_master_model_inst.send(16'h012c, rows[p], rows[p+1], rows[p+3:p+2+rows[p+1]], 1'b1);
      rd(16'h01a8);
      chk("echo", d, rows[p+3]);
      rd(16'h01a9);
      chk("outcome", d, rows[p+2]);
      p += 3 + rows[p+1];
    end
    chk("year", dt_year, 16'h0010);
    chk("hour minute", dt_hmin, 16'h0a0a);
    chk("msec", dt_msec, 16'h2710);
    chk("baud", baud_code, 16'h0006);
    chk("parity", parity_code, 16'h0001);
    chk("wiring", wiring_code, 16'h0004);
    chk("vt primary", vt_primary, 32'h0001_0002);
    chk("volt conn", volt_conn, 16'h0001);
    chk("freq vts", {nominal_freq, vt_secondary}, 32'h003c_0078);
    chk("coil primary", coil_primary, 32'h0000_0002);
    chk("rcoil primary", rcoil_primary, 32'h0000_0003);
    chk("secondaries", {coil_secondary, rcoil_secondary}, 32'h014d_014d);
    chk("mday iconn", {dt_mday, curr_conn}, 32'h0101_0001);
    mcc_master_model_inst.send(16'h012c, 16'h0004, 4, cw, 1'b0);
    mcc_master_model_inst.send(16'h012d, 16'h0004, 4, cw, 1'b1);
    mcc_master_model_inst.send(16'h01a8, 16'h0001, 1, rows[0:0], 1'b1);
    rd(16'h0050);
    chk("slave", d, 16'h00f7);
    rd(16'h01a8);
    chk("echo kept", d, 16'h03ea);
    rd(16'h01a9);
    chk("outcome kept", d, 16'h0053);
    rd(16'h01aa);
    chk("unmapped", {d, e}, 32'h0000_0001);
    nrst = 1'b0;
    @(posedge clk) #1 nrst = 1'b1;
    chk("slave again", slave_addr, 16'h0001);
    end_of_test();
  end
endmodule
bind mcc_cmd_config mcc_cmd_config_props mcc_cmd_config_props_inst (.*);
